// ---- fap_pkg.sv ----
// Shared constants and carriers for the four-pin auxiliary port.
// Assumes one core clock domain and an APB register bus with 32-bit data.
package fap_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIN_W = 3;
  localparam int unsigned SYNC_STAGES = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PIN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IST = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IMSK = 8'h14;

  // Field positions of the direction and slave status register
  localparam int unsigned IBF_BIT = 7;
  localparam int unsigned OBF_BIT = 6;
  localparam int unsigned OVR_BIT = 5;
  localparam int unsigned MODE_BIT = 4;
  localparam int unsigned RSV_BIT = 3;

  // Interrupt event positions
  localparam int unsigned EVT_HWR = 0;
  localparam int unsigned EVT_HRD = 1;
  localparam int unsigned EVT_OVR = 2;
  localparam int unsigned EVT_W = 3;

  // Values after reset
  localparam logic [PIN_W-1:0] LAT_RST = 3'h0;
  localparam logic [PIN_W-1:0] DIR_RST = 3'h7;
  localparam logic [PIN_W-1:0] ANA_RST = 3'h7;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
  localparam logic CLR_FN_RST = 1'b1;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } fap_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } fap_apb_rsp_t;

  typedef struct packed {
    logic host_wr_done;
    logic host_rd_done;
    logic cpu_in_read;
    logic cpu_out_write;
  } fap_psp_evt_t;

  typedef struct packed {
    logic enable;
    logic rd_n;
    logic wr_n;
    logic cs_n;
  } fap_psp_ctl_t;

endpackage

// ---- fap_sync.sv ----
// Multi-bit flip-flop synchroniser chain for pin levels.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ns
`default_nettype none
module fap_sync #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned STAGES = 2
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [WIDTH-1:0] d_i, // Raw pin levels
  output logic [WIDTH-1:0] q_o // Synchronised levels
);
  logic [WIDTH-1:0] stage_r [STAGES];

  generate
    if (STAGES < 2) begin : g_chk
      $error("fap_sync needs at least two stages");
    end
  endgenerate

  // Only the next stage reads each stage but the last, which drives q_o; the first is never decoded
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < STAGES; k++) begin
        stage_r[k] <= '0;
      end
    end else begin
      stage_r[0] <= d_i;
      for (int k = 1; k < STAGES; k++) begin
        stage_r[k] <= stage_r[k-1];
      end
    end
  end

  assign q_o = stage_r[STAGES-1];
endmodule
`default_nettype wire

// ---- fap_irq.sv ----
// Sticky event status with write-one-to-clear, mask and one level interrupt.
// Assumes event pulses and write strobes are in the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module fap_irq #(
  parameter int unsigned WIDTH = fap_pkg::EVT_W
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [WIDTH-1:0] evt_i, // Event pulses
  input wire logic clr_we_i, // Status write strobe
  input wire logic mask_we_i, // Mask write strobe
  input wire logic [WIDTH-1:0] wdata_i, // Write data
  output logic [WIDTH-1:0] status_o, // Sticky status
  output logic [WIDTH-1:0] mask_o, // Mask, 1 enables
  output logic irq_o // Level interrupt
);
  import fap_pkg::*;

  logic [WIDTH-1:0] st_nxt;
  logic [WIDTH-1:0] msk_nxt;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("fap_irq needs at least one event");
    end
  endgenerate

  // A new event beats a clear in the same cycle
  assign st_nxt = evt_i | (status_o & ~(clr_we_i ? wdata_i : '0));
  assign msk_nxt = mask_we_i ? wdata_i : mask_o;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
      mask_o <= WIDTH'(MASK_RST);
      irq_o <= 1'b0;
    end else begin
      status_o <= st_nxt;
      mask_o <= msk_nxt;
      irq_o <= |(st_nxt & msk_nxt);
    end
  end
endmodule
`default_nettype wire

// ---- fap_top.sv ----
// Auxiliary port: three two-way pins, one input-only pin, slave port status.
// Assumes an APB master on clk_i and an external slave-port engine that
// reports host and CPU buffer events as one-cycle pulses.
// Summary of operation
// - Large variant has four pins, three with individual direction control.
// - Pins set as analog read zero in the pin register; the slave strobes still follow their levels.
// - Direction 1 releases the driver; 0 drives the latch onto the pin.
// - Direction bits steer the drivers even when pins are analog.
// - After reset the three two-way pins are analog inputs.
// - Latch register reads back latch contents, not pin levels.
// - A driven pin reads its latch bit only when digital; set as analog it reads zero.
// - Fourth pin is input only; clear select 0 makes it digital input.
// - Small variant keeps only the input-only pin.
// - Input-only bit exists only with clear select 0; else reads zero.
// - Input full flag, bit 7, read only; set by host write.
// - Output full flag, bit 6, read only; clears once host reads.
// - Overrun, bit 5, set on write into full buffer; software clears.
// - Bit 4 selects slave port mode; bit 3 reads zero.
// - Reset clears status and mode bits and sets direction bits.
// - In slave mode with all three direction bits set, pins 0, 1, 2 become read, write and select strobes.
// - Slave mode is held off while the PWM block drives multiple outputs.
`timescale 1ns/1ns
`default_nettype none
module fap_top #(
  parameter int unsigned LARGE_PKG = 1, // 1: four-pin part, 0: one-pin part
  parameter int unsigned SYNC_STAGES = fap_pkg::SYNC_STAGES // Synchroniser depth
) (
  input wire logic clk_i, // Core clock, 25 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire fap_pkg::fap_apb_req_t apb_i, // APB request
  output fap_pkg::fap_apb_rsp_t apb_o, // APB response
  input wire logic [fap_pkg::PIN_W-1:0] pin_i, // Two-way pin levels
  output logic [fap_pkg::PIN_W-1:0] pin_o, // Two-way pin drive values
  output logic [fap_pkg::PIN_W-1:0] pin_oe_n_o, // Low while driving
  input wire logic input_only_pin_i, // Input-only pin level
  input wire logic clear_function_select_i, // Strap: 1 = master clear
  input wire logic pwm_multi_out_i, // PWM in dual or quad output mode
  input wire fap_pkg::fap_psp_evt_t psp_evt_i, // Slave port events
  output fap_pkg::fap_psp_ctl_t psp_ctl_o, // Slave port strobes
  output logic master_clear_req_o, // Master clear request
  output logic irq_o // Level interrupt
);
  import fap_pkg::*;

  localparam bit LARGE = (LARGE_PKG != 0);
  localparam int unsigned PAD_W = DATA_W - PIN_W - 1;
  localparam int unsigned HI_W = DATA_W - 8;
  // Strobes lag the pin by the synchroniser depth plus their own register
  localparam int SYNC_DLY_A = int'(SYNC_STAGES) + 1;

  generate
    if (LARGE_PKG > 1 || SYNC_STAGES < 2) begin : g_chk
      $error("fap_top: LARGE_PKG must be 0 or 1, SYNC_STAGES at least 2");
    end
  endgenerate

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction

  function automatic logic [DATA_W-1:0] pad3(input logic [PIN_W-1:0] v);
    return {{(DATA_W-PIN_W){1'b0}}, v};
  endfunction

  logic [PIN_W-1:0] lat_r;
  logic [PIN_W-1:0] dir_r;
  logic [PIN_W-1:0] ana_r;
  logic ibf_r;
  logic obf_r;
  logic ovr_r;
  logic mode_r;
  logic clr_fn_r;
  logic strap_done_r;
  logic master_clear_input_r;
  fap_psp_ctl_t ctl_r;
  fap_apb_rsp_t rsp_r;
  logic [PIN_W:0] pin_s;
  logic [EVT_W-1:0] ist;
  logic [EVT_W-1:0] imsk;

  fap_sync #(
    .WIDTH(PIN_W + 1),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({input_only_pin_i, pin_i}),
    .q_o(pin_s)
  );

  // Bus decode
  wire setup = apb_i.psel & ~apb_i.penable;
  wire access = apb_i.psel & apb_i.penable & rsp_r.pready;
  wire wr = access & apb_i.pwrite;
  wire [ADDR_W-1:0] adr = apb_i.paddr;
  wire [DATA_W-1:0] wd = apb_i.pwdata;
  wire sel_pin = hit(adr, OFS_PIN);
  wire sel_lat = hit(adr, OFS_LAT);
  wire sel_dir = hit(adr, OFS_DIR);
  wire sel_cfg = hit(adr, OFS_CFG);
  wire sel_ist = hit(adr, OFS_IST);
  wire sel_imsk = hit(adr, OFS_IMSK);
  wire mapped = sel_pin | sel_lat | sel_dir | sel_cfg | sel_ist | sel_imsk;
  // Latch and direction exist only on the large part
  wire wr_lat = wr & LARGE & (sel_pin | sel_lat);
  wire wr_dir = wr & LARGE & sel_dir;
  wire wr_cfg = wr & LARGE & sel_cfg;
  wire wr_ist = wr & sel_ist;
  wire wr_imsk = wr & sel_imsk;

  // Digital input paths; analog pins and absent pins read zero
  wire [PIN_W-1:0] dig_in = pin_s[PIN_W-1:0] & ~ana_r & {PIN_W{LARGE}};
  wire re3_in = pin_s[PIN_W] & ~clr_fn_r;

  // Slave port gating
  wire psp_ok = LARGE & mode_r & ~pwm_multi_out_i;
  wire strb_ok = psp_ok & (&dir_r);
  wire hwr = psp_evt_i.host_wr_done & psp_ok;
  wire hrd = psp_evt_i.host_rd_done & psp_ok;
  wire cin = psp_evt_i.cpu_in_read & psp_ok;
  wire cout = psp_evt_i.cpu_out_write & psp_ok;
  wire ovr_set = hwr & ibf_r;

  // Set wins over clear for every hardware flag
  wire ibf_nxt = hwr | (ibf_r & ~cin);
  wire obf_nxt = cout | (obf_r & ~hrd);
  wire ovr_nxt = ovr_set | (ovr_r & ~(wr_dir & ~wd[OVR_BIT]));
  wire mode_nxt = wr_dir ? wd[MODE_BIT] : mode_r;
  wire [PIN_W-1:0] dir_nxt = wr_dir ? wd[PIN_W-1:0] : dir_r;
  wire [PIN_W-1:0] lat_nxt = wr_lat ? wd[PIN_W-1:0] : lat_r;
  wire [PIN_W-1:0] ana_nxt = wr_cfg ? wd[PIN_W-1:0] : ana_r;

  // Read values
  wire [DATA_W-1:0] rd_pin = {{PAD_W{1'b0}}, re3_in, dig_in};
  wire [DATA_W-1:0] rd_lat = pad3(lat_r);
  wire [7:0] dir_byte = {ibf_r, obf_r, ovr_r, mode_r, 1'b0, dir_r};
  wire [DATA_W-1:0] rd_dir = LARGE ? {{HI_W{1'b0}}, dir_byte} : '0;
  wire [DATA_W-1:0] rd_cfg = pad3(ana_r);
  wire [DATA_W-1:0] rd_val =
    sel_pin ? rd_pin :
    sel_lat ? rd_lat :
    sel_dir ? rd_dir :
    sel_cfg ? rd_cfg :
    sel_ist ? {{(DATA_W-EVT_W){1'b0}}, ist} :
    sel_imsk ? {{(DATA_W-EVT_W){1'b0}}, imsk} : '0;

  wire [EVT_W-1:0] evt = {ovr_set, hrd, hwr};

  fap_irq #(
    .WIDTH(EVT_W)
  ) u_irq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .evt_i(evt),
    .clr_we_i(wr_ist),
    .mask_we_i(wr_imsk),
    .wdata_i(wd[EVT_W-1:0]),
    .status_o(ist),
    .mask_o(imsk),
    .irq_o(irq_o)
  );

  // Port state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_r <= LAT_RST;
      dir_r <= DIR_RST;
      ana_r <= ANA_RST;
      ibf_r <= 1'b0;
      obf_r <= 1'b0;
      ovr_r <= 1'b0;
      mode_r <= 1'b0;
    end else begin
      lat_r <= lat_nxt;
      dir_r <= dir_nxt;
      ana_r <= ana_nxt;
      ibf_r <= ibf_nxt;
      obf_r <= obf_nxt;
      ovr_r <= ovr_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Strap is caught on the first edge after release, never by the reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_fn_r <= CLR_FN_RST;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      clr_fn_r <= clear_function_select_i;
      strap_done_r <= 1'b1;
    end
  end

  // Strobes idle high unless the slave port is really in use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_r <= '{enable: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1};
      master_clear_input_r <= 1'b0;
    end else begin
      ctl_r.enable <= strb_ok;
      ctl_r.rd_n <= ~strb_ok | pin_s[0];
      ctl_r.wr_n <= ~strb_ok | pin_s[1];
      ctl_r.cs_n <= ~strb_ok | pin_s[2];
      master_clear_input_r <= clr_fn_r & ~pin_s[PIN_W];
    end
  end

  // Answer in the first access cycle; read data taken at the setup edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= setup;
      rsp_r.pslverr <= setup & ~mapped;
      rsp_r.prdata <= setup ? rd_val : '0;
    end
  end

  // Driver state is the direction register itself, so analog pins still drive
  assign pin_o = lat_r;
  assign pin_oe_n_o = dir_r;
  assign psp_ctl_o = ctl_r;
  assign master_clear_req_o = master_clear_input_r;
  assign apb_o = rsp_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  wire rd_setup = setup & ~apb_i.pwrite;

  AST_RST_STATE: assert property (
    !$past(rst_n_i) |-> (dir_r == DIR_RST && ana_r == ANA_RST
      && !ibf_r && !obf_r && !ovr_r && !mode_r))
    else $error("Port state wrong after reset");

  AST_ANA_READ_ZERO: assert property (
    (rd_setup && sel_pin && ana_r[0]) |=> !apb_o.prdata[0])
    else $error("Analog pin did not read zero");

  AST_LATCH_DRIVE: assert property (
    wr_lat |=> (pin_o == $past(wd[PIN_W-1:0])) ##1 (pin_o == $past(pin_o)))
    else $error("Pin drive does not follow latch write");

  AST_LATCH_READBACK: assert property (
    (rd_setup && sel_lat) |=> apb_o.prdata == pad3($past(lat_r)))
    else $error("Latch read does not return latch");

  AST_BIT3_ZERO: assert property (
    (rd_setup && sel_dir) |=> (apb_o.prdata[RSV_BIT] == 1'b0
      && apb_o.prdata[DATA_W-1:8] == '0))
    else $error("Reserved direction bits not zero");

  AST_RE3_GATED: assert property (
    (rd_setup && sel_pin && clr_fn_r) |=> !apb_o.prdata[PIN_W])
    else $error("Input-only bit visible while clear enabled");

  AST_IBF_SET: assert property (
    hwr |=> ibf_r)
    else $error("Host write did not set input full");

  AST_OBF_CLR: assert property (
    (hrd && !cout) |=> !obf_r)
    else $error("Host read did not clear output full");

  AST_OVR_SET: assert property (
    (hwr && ibf_r) |=> ovr_r ##1 (ovr_r || $past(wr_dir)))
    else $error("Overrun not flagged");

  AST_OVR_HOLD: assert property (
    (ovr_r && !(wr_dir && !wd[OVR_BIT])) |=> ovr_r)
    else $error("Overrun cleared without software");

  AST_STROBE_IDLE: assert property (
    (!psp_ok || pwm_multi_out_i) |=> (!psp_ctl_o.enable && psp_ctl_o.rd_n
      && psp_ctl_o.wr_n && psp_ctl_o.cs_n))
    else $error("Strobes active outside slave mode");

  AST_SYNC_DELAY: assert property (
    (strb_ok && $stable(strb_ok)) |-> ##SYNC_DLY_A
      (!strb_ok || psp_ctl_o.rd_n == $past(pin_i[0], SYNC_DLY_A)))
    else $error("Strobe does not follow pin after sync delay");

  AST_PREADY_PULSE: assert property (
    setup |=> apb_o.pready ##1 !apb_o.pready)
    else $error("Ready is not a single access cycle");

  AST_DIR_DRIVE: assert property (
    wr_dir |=> pin_oe_n_o == $past(wd[PIN_W-1:0]))
    else $error("Driver enables do not follow direction write");

  AST_ANA_WRITE: assert property (
    wr_cfg |=> ana_r == $past(wd[PIN_W-1:0]))
    else $error("Analog select did not take the write");

  AST_DIG_GATED: assert property (
    (rd_setup && sel_pin) |=> (apb_o.prdata[PIN_W-1:0] & $past(ana_r)) == '0)
    else $error("Analog pin level leaked into pin read");

  AST_MASTER_CLEAR_INPUT_ON: assert property (
    (clr_fn_r && !pin_s[PIN_W]) |=> master_clear_req_o)
    else $error("Master clear request missing");

  AST_MASTER_CLEAR_INPUT_OFF: assert property (
    !clr_fn_r |=> !master_clear_req_o)
    else $error("Master clear request while pin is digital");

  AST_SMALL_PART: assert property (
    LARGE || (pin_oe_n_o == DIR_RST && pin_o == LAT_RST && !psp_ctl_o.enable))
    else $error("Small part drives two-way pins");

  AST_SMALL_DIR_ZERO: assert property (
    (rd_setup && sel_dir && !LARGE) |=> apb_o.prdata == '0)
    else $error("Small part shows direction register");

  AST_MODE_READ: assert property (
    (rd_setup && sel_dir && LARGE) |=> apb_o.prdata[MODE_BIT] == $past(mode_r))
    else $error("Mode bit read back wrong");

  AST_IBF_CLR: assert property (
    (cin && !hwr) |=> !ibf_r)
    else $error("CPU read did not clear input full");

  AST_OBF_SET: assert property (
    cout |=> obf_r)
    else $error("CPU write did not set output full");

  AST_EVT_GATED: assert property (
    !psp_ok |=> ($stable(ibf_r) && $stable(obf_r)))
    else $error("Buffer flags moved outside slave mode");

  AST_IRQ_LEVEL: assert property (
    irq_o == |(ist & imsk))
    else $error("Interrupt does not match masked status");

  AST_SLVERR: assert property (
    (setup && !mapped) |=> (apb_o.pslverr && apb_o.prdata == '0))
    else $error("Unmapped access not refused");

  COV_HOST_WRITE: cover property (hwr ##1 ibf_r ##[1:20] cin);
  COV_OVERRUN: cover property (ovr_set ##1 irq_o);
  COV_SLAVE_ON: cover property (wr_dir && wd[MODE_BIT] ##[1:4] psp_ctl_o.enable);
  COV_DRIVE_PIN: cover property (wr_dir && !wd[0] ##1 !pin_oe_n_o[0]);
  COV_IRQ_CLEAR: cover property ((irq_o && wr_ist) ##1 !irq_o);
endmodule
`default_nettype wire

// ---- fap_pin_model.sv ----
// Pin-side partner: the outside circuitry on the three two-way pins.
// Assumes the bench says when the outside world drives each pin.
`timescale 1ns/1ns
`default_nettype none
module fap_pin_model
  import fap_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic [PIN_W-1:0] pin_i, // Design drive values
  input wire logic [PIN_W-1:0] oe_n_i, // Design enables, low drives
  input wire logic [PIN_W-1:0] ext_val_i, // Outside drive values
  input wire logic [PIN_W-1:0] ext_en_i, // Outside drive enables
  output logic [PIN_W-1:0] level_o // Resolved pin levels
);
  logic [PIN_W-1:0] float_r = 3'h0;

  // No pull on these pins, so a floating pin flips every cycle
  always @(posedge clk_i) begin
    float_r <= ~level_o;
  end

  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (!oe_n_i[i] && ext_en_i[i]) begin
        level_o[i] = 1'bx;
      end else if (!oe_n_i[i]) begin
        level_o[i] = pin_i[i];
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_val_i[i];
      end else begin
        level_o[i] = float_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// ---- fap_tb.sv ----
// Self-checking bench for the auxiliary port, APB master plus pin partner.
// Assumes the event pulses of the slave-port engine come from this bench.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  import fap_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  fap_apb_req_t apb_i = '0;
  fap_apb_rsp_t apb_o;
  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_o;
  logic [PIN_W-1:0] pin_oe_n_o;
  logic [PIN_W-1:0] ext_val = 3'h0;
  logic [PIN_W-1:0] ext_en = 3'h0;
  logic io_pin = 1'b1;
  logic strap = 1'b1;
  logic pwm = 1'b0;
  fap_psp_evt_t evt = '0;
  fap_psp_ctl_t psp_ctl_o;
  logic master_clear_input_o;
  logic irq_o;
  fap_apb_rsp_t sm_apb;
  logic [PIN_W-1:0] sm_pin_o;
  logic [PIN_W-1:0] sm_oe_n;
  fap_psp_ctl_t sm_ctl;
  logic [31:0] sm_rd;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 32'hcb88;
  logic [31:0] rd;
  logic err;
  logic [2:0] v;
  logic [2:0] l;

  always #20 clk_i = ~clk_i;

  fap_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
    .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .input_only_pin_i(io_pin),
    .clear_function_select_i(strap), .pwm_multi_out_i(pwm), .psp_evt_i(evt),
    .psp_ctl_o(psp_ctl_o), .master_clear_req_o(master_clear_input_o), .irq_o(irq_o));

  fap_pin_model pins (.clk_i(clk_i), .pin_i(pin_o), .oe_n_i(pin_oe_n_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_lvl));

  // One-pin variant on the same bus and pins; only its outputs are compared
  fap_top #(.LARGE_PKG(0)) uut_small (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i),
    .apb_o(sm_apb), .pin_i(pin_lvl), .pin_o(sm_pin_o), .pin_oe_n_o(sm_oe_n),
    .input_only_pin_i(io_pin), .clear_function_select_i(strap), .pwm_multi_out_i(pwm),
    .psp_evt_i(evt), .psp_ctl_o(sm_ctl), .master_clear_req_o(), .irq_o());

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    // The wait ends when ready is seen; only the watchdog ends a wait for a ready that never comes
    do begin
      @(posedge clk_i);
    end while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    sm_rd = sm_apb.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("prdata", exp, rd)
  endtask

  task automatic pulse(input fap_psp_evt_t e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    @(posedge clk_i);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    strap <= s;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  function automatic logic [31:0] exp_pin(input logic [2:0] ana, input logic [2:0] lv,
      input logic s, input logic io);
    return {28'h000_0000, ~s & io, lv & ~ana};
  endfunction

  task automatic wrap_up();
    $display("counts: checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    wrap_up();
  end

  initial begin
    do_reset(1'b1);
    `CHK("oe_n", 3'h7, pin_oe_n_o)
    rchk(OFS_DIR, 32'h0000_0007);
    rchk(OFS_LAT, 32'h0000_0000);
    ext_en <= 3'h7;
    ext_val <= 3'h5;
    io_pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(OFS_PIN, 32'h0000_0000);
    `CHK("small pin", 32'h0000_0000, sm_rd)
    `CHK("master_clear_input", 1'b1, master_clear_input_o)
    $display("test reset done");
    apb(1'b1, OFS_CFG, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      v = 3'($random(seed));
      l = ~v;
      ext_val <= v;
      apb(1'b1, OFS_LAT, {29'h0000_0000, l});
      repeat (4) @(posedge clk_i);
      rchk(OFS_PIN, exp_pin(3'h0, v, 1'b1, io_pin));
      rchk(OFS_LAT, {29'h0000_0000, l});
    end
    apb(1'b1, OFS_CFG, 32'h0000_0005);
    rchk(OFS_PIN, exp_pin(3'h5, v, 1'b1, io_pin));
    ext_en <= 3'h0;
    apb(1'b1, OFS_DIR, 32'h0000_0000);
    @(posedge clk_i);
    `CHK("oe_n", 3'h0, pin_oe_n_o)
    `CHK("pin_o", l, pin_o)
    `CHK("small oe_n", 3'h7, sm_oe_n)
    `CHK("small pin_o", 3'h0, sm_pin_o)
    repeat (4) @(posedge clk_i);
    rchk(OFS_PIN, exp_pin(3'h5, l, 1'b1, io_pin));
    apb(1'b1, OFS_DIR, 32'h0000_0007);
    ext_en <= 3'h7;
    $display("test pins done");
    apb(1'b1, OFS_IMSK, 32'h0000_0007);
    apb(1'b1, OFS_DIR, 32'hFFFF_FFFF);
    rchk(OFS_DIR, 32'h0000_0017);
    `CHK("small dir", 32'h0000_0000, sm_rd)
    repeat (5) @(posedge clk_i);
    `CHK("psp_en", 1'b1, psp_ctl_o.enable)
    `CHK("small psp_en", 1'b0, sm_ctl.enable)
    `CHK("strobes", v, {psp_ctl_o.cs_n, psp_ctl_o.wr_n, psp_ctl_o.rd_n})
    pulse(4'h8);
    `CHK("irq", 1'b1, irq_o)
    rchk(OFS_DIR, 32'h0000_0097);
    pulse(4'h8);
    rchk(OFS_DIR, 32'h0000_00B7);
    rchk(OFS_IST, 32'h0000_0005);
    pulse(4'h2);
    rchk(OFS_DIR, 32'h0000_0037);
    apb(1'b1, OFS_DIR, 32'h0000_0017);
    rchk(OFS_DIR, 32'h0000_0017);
    pulse(4'h1);
    rchk(OFS_DIR, 32'h0000_0057);
    pulse(4'h4);
    rchk(OFS_DIR, 32'h0000_0017);
    rchk(OFS_IST, 32'h0000_0007);
    apb(1'b1, OFS_IMSK, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    apb(1'b1, OFS_IMSK, 32'h0000_0007);
    apb(1'b1, OFS_IST, 32'h0000_0007);
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    rchk(OFS_IST, 32'h0000_0000);
    pwm <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("psp_en", 1'b0, psp_ctl_o.enable)
    pulse(4'h8);
    rchk(OFS_DIR, 32'h0000_0017);
    pwm <= 1'b0;
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("pslverr", 1'b1, err)
    `CHK("prdata", 32'h0000_0000, rd)
    $display("test slave port done");
    do_reset(1'b0);
    io_pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk(OFS_DIR, 32'h0000_0007);
    rchk(OFS_PIN, exp_pin(3'h7, v, 1'b0, 1'b1));
    `CHK("small pin", 32'h0000_0008, sm_rd)
    `CHK("master_clear_input", 1'b0, master_clear_input_o)
    `CHK("psp_en", 1'b0, psp_ctl_o.enable)
    io_pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(OFS_PIN, 32'h0000_0000);
    `CHK("master_clear_input", 1'b0, master_clear_input_o)
    $display("test input-only pin done");
    wrap_up();
  end
endmodule
`default_nettype wire
